// File: inc/rrs_pkg.sv
package rrs_pkg;

    // APB register byte addresses.
    localparam logic [7:0] ADDR_CMD    = 8'h00;
    localparam logic [7:0] ADDR_ACC    = 8'h04;
    localparam logic [7:0] ADDR_STAT   = 8'h08;
    localparam logic [7:0] ADDR_REPEAT_COUNTER   = 8'h0C;
    localparam logic [7:0] ADDR_ARP    = 8'h10;
    localparam logic [7:0] ADDR_MEMCFG = 8'h14;
    localparam logic [7:0] ADDR_WAIT   = 8'h18;
    localparam logic [7:0] ADDR_MADDR  = 8'h1C;
    localparam logic [7:0] ADDR_MDATA  = 8'h20;
    localparam logic [7:0] ADDR_AR0    = 8'h40;
    localparam logic [7:0] ADDR_DPAGE  = 8'h24;
    localparam logic [7:0] ADDR_OPND   = 8'h28;

    // Instruction word opcode fields.
    localparam logic [15:0] OPC_ROR      = 16'hBE01;
    localparam logic [7:0]  OPC_RPT_MEM  = 8'h0B;
    localparam logic [7:0]  OPC_RPT_IMM  = 8'hBB;
    localparam logic [4:0]  OPC_STORE_ACC_HIGH_OP     = 5'h13;
    localparam logic [4:0]  OPC_STORE_ACC_LOW_OP     = 5'h12;
    localparam logic [4:0]  OPC_SAR      = 5'h10;
    localparam logic [7:0]  OPC_AUX_SUB_IMM_OP     = 8'h7C;
    localparam int          IND_BIT      = 7;

    // Memory placement codes.
    localparam logic [1:0] LOC_DUAL_ACCESS_RAM = 2'h0;
    localparam logic [1:0] LOC_SINGLE_ACCESS_RAM = 2'h1;
    localparam logic [1:0] LOC_EXT   = 2'h2;
    localparam logic [1:0] LOC_ROM   = 2'h3;

    localparam logic [31:0] ACC_RESET  = 32'h0000_0000;
    localparam logic [15:0] REPEAT_COUNTER_RESET = 16'h0000;
    localparam logic [7:0]  WAIT_RESET = 8'h00;

    typedef struct packed {
        logic [1:0] prog_loc;
        logic [1:0] opnd_loc;
        logic       same_block;
    } mem_cfg_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_BUSY = 3'b010,
        ST_DONE = 3'b100
    } exec_state_t;

endpackage : rrs_pkg

// File: core/rotate_repeat_store_ops.sv
// The placing of the registers and the APB register port were decided locally.
`timescale 1ns/1ns
module rotate_repeat_store_ops
    import rrs_pkg::*;
#(
    parameter int AR_COUNT = 8
) (
    input  wire logic        core_clk_in,   // CPU clock
    input  wire logic        rstn_in,       // Asynchronous reset, active low
    input  wire logic        psel_in,       // APB select
    input  wire logic        penable_in,    // APB enable
    input  wire logic        pwrite_in,     // APB direction
    input  wire logic [7:0]  paddr_in,      // APB byte address
    input  wire logic [31:0] pwdata_in,     // APB write data
    output logic      [31:0] prdata_out,    // APB read data
    output logic             pready_out,    // APB ready
    output logic             pslverr_out,   // APB error on unmapped address
    output logic             sxm_out        // Sign extension mode, unused here
);

    if (AR_COUNT != 8) begin : g_bad_ar_count
        $error("AR_COUNT must be 8");
    end

    logic [31:0]     acc;
    logic            carry;
    logic [15:0]     repeat_counter;
    logic            rpt_armed;
    logic [2:0]      aux_pointer;
    logic [15:0]     ar [8];
    mem_cfg_t        cfg;
    logic [7:0]      wait_d;
    logic [7:0]      wait_p;
    logic [8:0]      dpage;
    logic [15:0]     opnd;
    logic [15:0]     mem_addr;
    logic [15:0]     mem_data;
    logic            mem_we;
    logic [15:0]     instr;
    exec_state_t     state;
    logic [15:0]     cyc_left;
    logic [15:0]     cyc_total;
    logic            sign_ext_mode_bit;
    logic [15:0]     ror_left;

    wire apb_wr = psel_in && penable_in && pwrite_in;
    wire apb_rd = psel_in && penable_in && !pwrite_in;
    wire cmd_go = apb_wr && (paddr_in == ADDR_CMD) && (state == ST_IDLE);
    wire [15:0] cmd = pwdata_in[15:0];

    function automatic logic [31:0] out_shift(input logic [31:0] a, input logic [2:0] s);
        out_shift = a << s;
    endfunction : out_shift

    // Effective address: direct uses page and seven-bit offset, else current aux.
    function automatic logic [15:0] eff_addr(input logic [15:0] w, input logic [8:0] dp,
                                             input logic [15:0] cur);
        if (w[IND_BIT]) begin
            eff_addr = cur;
        end else begin
            eff_addr = {dp, w[6:0]};
        end
    endfunction : eff_addr

    function automatic logic [15:0] ar_modify(input logic [15:0] v, input logic [2:0] aru,
                                              input logic [15:0] ar0);
        case (aru)
            3'h1: ar_modify = v - 16'h0001;
            3'h2: ar_modify = v + 16'h0001;
            3'h5: ar_modify = v - ar0;
            3'h6: ar_modify = v + ar0;
            default: ar_modify = v;
        endcase
    endfunction : ar_modify

    // Store cycle count for one pass, or all passes when repeated.
    function automatic logic [15:0] store_cycles(input mem_cfg_t c, input logic [15:0] n,
                                                 input logic rep, input logic [7:0] d,
                                                 input logic [7:0] p);
        logic [15:0] k;
        k = rep ? n : 16'h0001;
        if (c.opnd_loc == LOC_EXT) begin
            if (c.prog_loc == LOC_EXT) begin
                store_cycles = 16'(2 * k) + 16'h0002 + 16'(k * d) + 16'(p);
            end else begin
                store_cycles = 16'(2 * k) + 16'(k * d);
            end
        end else if (c.prog_loc == LOC_EXT) begin
            store_cycles = k + 16'(p);
        end else if (c.same_block && c.opnd_loc == LOC_SINGLE_ACCESS_RAM && c.prog_loc == LOC_SINGLE_ACCESS_RAM) begin
            store_cycles = rep ? k + 16'h0002 : 16'h0002;
        end else begin
            store_cycles = k;
        end
    endfunction : store_cycles

    wire ext_p = (cfg.prog_loc == LOC_EXT);
    wire ext_d = (cfg.opnd_loc == LOC_EXT);
    wire is_ror  = (cmd == OPC_ROR);
    wire is_rptm = (cmd[15:8] == OPC_RPT_MEM);
    wire is_rpti = (cmd[15:8] == OPC_RPT_IMM);
    wire is_store_acc_high_op = (cmd[15:11] == OPC_STORE_ACC_HIGH_OP);
    wire is_store_acc_low_op = (cmd[15:11] == OPC_STORE_ACC_LOW_OP);
    wire is_sar  = (cmd[15:11] == OPC_SAR);
    wire is_aux_sub_imm_op = (cmd[15:8] == OPC_AUX_SUB_IMM_OP);
    wire [15:0] reps = repeat_counter + 16'h0001;
    wire [15:0] cur_ar = ar[aux_pointer];
    wire [31:0] shifted = out_shift(acc, cmd[10:8]);
    wire same_sa = cfg.same_block && (cfg.opnd_loc == LOC_SINGLE_ACCESS_RAM) && (cfg.prog_loc == LOC_SINGLE_ACCESS_RAM);

    always_comb begin
        cyc_total = 16'h0001;
        if (is_ror) begin
            cyc_total = (rpt_armed ? reps : 16'h0001) + (ext_p ? 16'(wait_p) : 16'h0000);
        end else if (is_rptm) begin
            if (ext_d && ext_p) begin
                cyc_total = 16'h0002 + 16'(wait_d) + 16'(wait_p);
            end else if (ext_d) begin
                cyc_total = 16'h0001 + 16'(wait_d);
            end else if (ext_p) begin
                cyc_total = 16'h0001 + 16'(wait_p);
            end else if (same_sa) begin
                cyc_total = 16'h0002;
            end else begin
                cyc_total = 16'h0001;
            end
        end else if (is_rpti || is_aux_sub_imm_op) begin
            cyc_total = 16'h0001 + (ext_p ? 16'(wait_p) : 16'h0000);
        end else if (is_store_acc_high_op || is_store_acc_low_op || is_sar) begin
            cyc_total = store_cycles(cfg, reps, rpt_armed, wait_d, wait_p);
        end
    end

    // Execution timing: the instruction completes when its cycle count runs out.
    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            state    <= ST_IDLE;
            cyc_left <= 16'h0000;
            instr    <= 16'h0000;
        end else begin
            case (state)
                ST_IDLE: begin
                    if (cmd_go) begin
                        instr    <= cmd;
                        cyc_left <= cyc_total - 16'h0001;
                        state    <= (cyc_total == 16'h0001) ? ST_DONE : ST_BUSY;
                    end
                end
                ST_BUSY: begin
                    cyc_left <= cyc_left - 16'h0001;
                    if (cyc_left == 16'h0001) begin
                        state <= ST_DONE;
                    end
                end
                ST_DONE: state <= ST_IDLE;
                default: state <= ST_IDLE;
            endcase
        end
    end

    // Accumulator and carry; stores never touch them.
    // A repeated rotate turns once more per cycle while its copy of the counter runs down;
    // except when the counter plus the external program wait states exceeds 16'hFFFF, the cycle count covers these turns and bus writes cannot interleave.
    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            acc      <= ACC_RESET;
            carry    <= 1'b0;
            ror_left <= 16'h0000;
        end else if (apb_wr && paddr_in == ADDR_ACC && state == ST_IDLE) begin
            acc <= pwdata_in;
        end else if (apb_wr && paddr_in == ADDR_STAT && state == ST_IDLE) begin
            carry <= pwdata_in[0];
        end else if (cmd_go && is_ror) begin
            acc      <= {carry, acc[31:1]};
            carry    <= acc[0];
            ror_left <= rpt_armed ? repeat_counter : 16'h0000;
        end else if (ror_left != 16'h0000) begin
            acc      <= {carry, acc[31:1]};
            carry    <= acc[0];
            ror_left <= ror_left - 16'h0001;
        end
    end

    // Repeat counter: loaded by repeat, consumed by the next instruction.
    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            repeat_counter      <= REPEAT_COUNTER_RESET;
            rpt_armed <= 1'b0;
        end else if (cmd_go && is_rptm) begin
            repeat_counter      <= opnd;
            rpt_armed <= 1'b1;
        end else if (cmd_go && is_rpti) begin
            repeat_counter      <= {8'h00, cmd[7:0]};
            rpt_armed <= 1'b1;
        end else if (cmd_go) begin
            repeat_counter      <= REPEAT_COUNTER_RESET;
            rpt_armed <= 1'b0;
        end
    end

    // Auxiliary registers, pointer and arithmetic unit.
    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            aux_pointer <= 3'h0;
            for (int i = 0; i < 8; i++) begin
                ar[i] <= 16'h0000;
            end
        end else if (apb_wr && paddr_in[7:5] == ADDR_AR0[7:5] && state == ST_IDLE) begin
            ar[paddr_in[4:2]] <= pwdata_in[15:0];
        end else if (apb_wr && paddr_in == ADDR_ARP && state == ST_IDLE) begin
            aux_pointer <= pwdata_in[2:0];
        end else if (cmd_go && is_aux_sub_imm_op) begin
            ar[aux_pointer] <= cur_ar - {8'h00, cmd[7:0]};
        end else if (cmd_go && cmd[IND_BIT] && (is_store_acc_high_op || is_store_acc_low_op || is_sar || is_rptm)) begin
            ar[aux_pointer] <= ar_modify(cur_ar, cmd[6:4], ar[0]);
            if (cmd[3]) begin
                aux_pointer <= cmd[2:0];
            end
        end
    end

    // Data-memory write port image, taken before any aux modification.
    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            mem_addr <= 16'h0000;
            mem_data <= 16'h0000;
            mem_we   <= 1'b0;
        end else if (cmd_go && (is_store_acc_high_op || is_store_acc_low_op || is_sar)) begin
            mem_addr <= eff_addr(cmd, dpage, cur_ar);
            mem_we   <= 1'b1;
            if (is_store_acc_high_op) begin
                mem_data <= shifted[31:16];
            end else if (is_store_acc_low_op) begin
                mem_data <= shifted[15:0];
            end else begin
                mem_data <= ar[cmd[10:8]];
            end
        end else if (cmd_go) begin
            mem_we <= 1'b0;
        end
    end

    // Configuration registers.
    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            cfg    <= '0;
            wait_d <= WAIT_RESET;
            wait_p <= WAIT_RESET;
            dpage  <= 9'h000;
            opnd   <= 16'h0000;
            sign_ext_mode_bit    <= 1'b0;
        end else if (apb_wr && state == ST_IDLE) begin
            if (paddr_in == ADDR_MEMCFG) begin
                cfg <= pwdata_in[4:0];
            end else if (paddr_in == ADDR_WAIT) begin
                wait_d <= pwdata_in[7:0];
                wait_p <= pwdata_in[15:8];
            end else if (paddr_in == ADDR_DPAGE) begin
                dpage <= pwdata_in[8:0];
            end else if (paddr_in == ADDR_OPND) begin
                opnd <= pwdata_in[15:0];
            end else if (paddr_in == ADDR_STAT) begin
                sign_ext_mode_bit <= pwdata_in[1];
            end
        end
    end

    assign sxm_out = sign_ext_mode_bit;

    wire mapped = (paddr_in == ADDR_CMD) || (paddr_in == ADDR_ACC) || (paddr_in == ADDR_STAT)
               || (paddr_in == ADDR_REPEAT_COUNTER) || (paddr_in == ADDR_ARP) || (paddr_in == ADDR_MEMCFG)
               || (paddr_in == ADDR_WAIT) || (paddr_in == ADDR_MADDR)
               || (paddr_in == ADDR_MDATA) || (paddr_in == ADDR_DPAGE)
               || (paddr_in == ADDR_OPND) || (paddr_in[7:5] == ADDR_AR0[7:5]);

    assign pready_out  = 1'b1;
    assign pslverr_out = psel_in && penable_in && !mapped;

    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            prdata_out <= 32'h0000_0000;
        end else if (psel_in && !penable_in && !pwrite_in) begin
            if (paddr_in == ADDR_CMD) begin
                prdata_out <= {13'h0000, state, instr};
            end else if (paddr_in == ADDR_ACC) begin
                prdata_out <= acc;
            end else if (paddr_in == ADDR_STAT) begin
                prdata_out <= {28'h0000000, rpt_armed, state == ST_IDLE, sign_ext_mode_bit, carry};
            end else if (paddr_in == ADDR_REPEAT_COUNTER) begin
                prdata_out <= {16'h0000, repeat_counter};
            end else if (paddr_in == ADDR_ARP) begin
                prdata_out <= {29'h00000000, aux_pointer};
            end else if (paddr_in == ADDR_MEMCFG) begin
                prdata_out <= {27'h0000000, cfg};
            end else if (paddr_in == ADDR_WAIT) begin
                prdata_out <= {16'h0000, wait_p, wait_d};
            end else if (paddr_in == ADDR_MADDR) begin
                prdata_out <= {15'h0000, mem_we, mem_addr};
            end else if (paddr_in == ADDR_MDATA) begin
                prdata_out <= {16'h0000, mem_data};
            end else if (paddr_in == ADDR_DPAGE) begin
                prdata_out <= {23'h000000, dpage};
            end else if (paddr_in == ADDR_OPND) begin
                prdata_out <= {16'h0000, opnd};
            end else if (paddr_in[7:5] == ADDR_AR0[7:5]) begin
                prdata_out <= {16'h0000, ar[paddr_in[4:2]]};
            end else begin
                prdata_out <= 32'h0000_0000;
            end
        end
    end

    sequence s_ror_go;
        cmd_go && is_ror;
    endsequence

    a_ror_acc_move: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
        s_ror_go |=> acc == {$past(carry), $past(acc[31:1])})
        else $error("rotate right accumulator wrong");
    a_ror_carry_in: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
        s_ror_go |=> carry == $past(acc[0]))
        else $error("rotate right carry wrong");
    a_ror_one_cycle: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
        (s_ror_go and (!rpt_armed && !ext_p)) |=> state == ST_DONE)
        else $error("rotate right not one cycle");
    a_ror_repeat_turn: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
        (ror_left != 16'h0000) |=> acc == {$past(carry), $past(acc[31:1])})
        else $error("repeated rotate step wrong");
    a_rpt_imm_load: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
        (cmd_go && is_rpti) |=> repeat_counter == {8'h00, $past(cmd[7:0])} && rpt_armed)
        else $error("repeat immediate load wrong");
    a_rpt_mem_load: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
        (cmd_go && is_rptm) |=> repeat_counter == $past(opnd) && rpt_armed)
        else $error("repeat memory load wrong");
    a_rpt_clear: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
        (cmd_go && !is_rptm && !is_rpti) |=> repeat_counter == REPEAT_COUNTER_RESET && !rpt_armed)
        else $error("repeat counter not cleared");
    a_store_acc_high_op_data: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
        (cmd_go && is_store_acc_high_op) |=> mem_data == 16'(($past(acc) << $past(cmd[10:8])) >> 16))
        else $error("high store data wrong");
    a_store_acc_low_op_data: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
        (cmd_go && is_store_acc_low_op) |=> mem_data == 16'($past(acc) << $past(cmd[10:8])))
        else $error("low store data wrong");
    a_store_acc_kept: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
        (cmd_go && (is_store_acc_high_op || is_store_acc_low_op)) |=> $stable(acc))
        else $error("store changed accumulator");
    a_aux_status_kept: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
        (cmd_go && (is_sar || is_aux_sub_imm_op)) |=> carry == $past(carry) && sign_ext_mode_bit == $past(sign_ext_mode_bit))
        else $error("aux operation changed status");
    a_aux_sub_imm_op_diff: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
        (cmd_go && is_aux_sub_imm_op) |=> ar[$past(aux_pointer)] == $past(cur_ar) - {8'h00, $past(cmd[7:0])})
        else $error("aux subtract wrong");
    a_direct_addr: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
        (cmd_go && is_sar && !cmd[IND_BIT]) |=> mem_addr[6:0] == $past(cmd[6:0]))
        else $error("direct address wrong");

endmodule : rotate_repeat_store_ops

// File: tb/apb_host.sv
`timescale 1ns/1ns
module apb_host (
    input  wire logic        clk_in,      // Bus clock
    input  wire logic [31:0] prdata_in,   // Read data
    input  wire logic        pready_in,   // Ready
    input  wire logic        pslverr_in,  // Error response
    output logic             psel_out,    // Select
    output logic             penable_out, // Enable
    output logic             pwrite_out,  // Direction
    output logic [7:0]       paddr_out,   // Byte address
    output logic [31:0]      pwdata_out   // Write data
);
    initial begin
        psel_out    = 1'b0;
        penable_out = 1'b0;
        pwrite_out  = 1'b0;
        paddr_out   = 8'hFF;
        pwdata_out  = 32'h0;
    end

    // The request stays put until ready is seen high at a rising edge.
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                        output logic [31:0] rd, output logic err);
        @(posedge clk_in);
        psel_out    <= 1'b1;
        penable_out <= 1'b0;
        pwrite_out  <= wr;
        paddr_out   <= a;
        pwdata_out  <= wd;
        @(posedge clk_in);
        penable_out <= 1'b1;
        @(posedge clk_in);
        while (pready_in !== 1'b1) @(posedge clk_in);
        rd = prdata_in;
        err = pslverr_in;
        psel_out    <= 1'b0;
        penable_out <= 1'b0;
        paddr_out   <= ~a;
        pwdata_out  <= ~wd;
    endtask : xfer
endmodule : apb_host

// File: tb/testbench.sv
`timescale 1ns/1ns
module testbench;
    import rrs_pkg::*;
    logic        core_clk_in, rstn_in, psel, penable, pwrite, pready, pslverr, sign_ext_mode_bit, err;
    logic [7:0]  paddr, k;
    logic [31:0] pwdata, prdata, rd, a, sv;
    logic [15:0] ar [8];
    logic [6:0]  dma;
    logic [8:0]  dp;
    logic [4:0]  cfg;
    logic [2:0]  sh, x, aux_pointer, aru, nar;
    logic        c, s, hi;
    int          errors, n_checks, cyc, t, base, d, p;

    rotate_repeat_store_ops u_rotate_repeat_store_ops (
        .core_clk_in(core_clk_in), .rstn_in(rstn_in), .psel_in(psel), .penable_in(penable),
        .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
        .pready_out(pready), .pslverr_out(pslverr), .sxm_out(sign_ext_mode_bit));
    apb_host u_apb_host (
        .clk_in(core_clk_in), .prdata_in(prdata), .pready_in(pready), .pslverr_in(pslverr),
        .psel_out(psel), .penable_out(penable), .pwrite_out(pwrite), .paddr_out(paddr),
        .pwdata_out(pwdata));

    initial begin
        core_clk_in = 1'b0;
        forever #20 core_clk_in = ~core_clk_in;
    end

    task automatic close_out();
        $display("checks %0d mismatches %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : close_out

    // The run is a few thousand cycles; the ceiling only catches a hang.
    always @(posedge core_clk_in) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            errors++;
            close_out();
        end
    end

    task automatic wr(input logic [7:0] ad, input logic [31:0] wd);
        u_apb_host.xfer(1'b1, ad, wd, rd, err);
    endtask : wr
    task automatic rdr(input logic [7:0] ad);
        u_apb_host.xfer(1'b0, ad, 32'h0, rd, err);
    endtask : rdr
    task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            errors++;
            $display("Error %s expected %h seen %h", what, e, g);
        end
    endtask : chk
    task automatic run(input logic [15:0] ins);
        int t0;
        wr(ADDR_CMD, {16'h0, ins});
        t0 = cyc;
        rd = 32'h0;
        while (rd[2] !== 1'b1) rdr(ADDR_STAT);
        t = cyc - t0;
    endtask : run
    // Idle is polled once every three cycles, so the busy time is rounded to the nearest multiple of that step.
    task automatic tchk(input int e);
        int ex;
        ex = base + 3 * ((e + 1) / 3);
        n_checks++;
        if (t != ex) begin
            errors++;
            $display("Error cycles expected %0d seen %0d", ex, t);
        end
    endtask : tchk
    // Kind 0 plain, 1 repeat from memory, 2 single store, 3 repeated store.
    function automatic int expc(input int kind, input logic [4:0] f, input int n, dd, pw);
        bit pe, oe, sb;
        int pp;
        pe = f[4:3] == LOC_EXT;
        oe = f[2:1] == LOC_EXT;
        sb = f[0] && f[4:3] == LOC_SINGLE_ACCESS_RAM && f[2:1] == LOC_SINGLE_ACCESS_RAM;
        pp = pe ? pw : 0;
        case (kind)
            0: return n + pp;
            1: return oe ? (pe ? 2 + dd + pw : 1 + dd) : (sb ? 2 : 1 + pp);
            2: return oe ? (pe ? 4 + dd + pw : 2 + dd) : (sb ? 2 : 1 + pp);
            default: return oe ? (pe ? 2*n + 2 + n*dd + pw : 2*n + n*dd) : (sb ? n + 2 : n + pp);
        endcase
    endfunction : expc
    task automatic done(input string nm);
        $display("test %s finished", nm);
    endtask : done

    initial begin
        rstn_in = 1'b0;
        errors = 0;
        n_checks = 0;
        void'($urandom(94));
        repeat (20) @(posedge core_clk_in);
        rstn_in <= 1'b1;
        rdr(ADDR_ACC);
        chk("acc", ACC_RESET, rd);
        rdr(ADDR_REPEAT_COUNTER);
        chk("repeat_counter", {16'h0, REPEAT_COUNTER_RESET}, rd);
        rdr(ADDR_STAT);
        chk("stat", 32'h4, rd);
        rdr(8'hFC);
        chk("pslverr", 32'h1, {31'h0, err});
        chk("pready", 32'h1, {31'h0, pready});
        done("reset");
        for (int i = 0; i < 16; i++) begin
            a = (i == 0) ? 32'h1 : (i == 1) ? 32'h8000_0000 : $urandom;
            c = (i == 1) ? 1'b1 : (i == 0) ? 1'b0 : 1'($urandom);
            s = 1'($urandom);
            wr(ADDR_ACC, a);
            wr(ADDR_STAT, {30'h0, s, c});
            run(OPC_ROR);
            rdr(ADDR_ACC);
            chk("ror acc", {c, a[31:1]}, rd);
            rdr(ADDR_STAT);
            chk("ror carry", {31'h0, a[0]}, {31'h0, rd[0]});
            chk("sxm", {31'h0, s}, {31'h0, sign_ext_mode_bit});
        end
        done("rotate");
        for (int i = 0; i < 24; i++) begin
            a = (i < 2) ? 32'hFFFF_FFFF : $urandom;
            sh = (i < 2) ? 3'h7 : 3'($urandom);
            hi = i[0];
            dma = 7'($urandom);
            s = 1'($urandom);
            wr(ADDR_ACC, a);
            wr(ADDR_STAT, {30'h0, s, 1'b0});
            dp = 9'($urandom);
            wr(ADDR_DPAGE, {23'h0, dp});
            run({hi ? OPC_STORE_ACC_HIGH_OP : OPC_STORE_ACC_LOW_OP, sh, 1'b0, dma});
            sv = a << sh;
            rdr(ADDR_MDATA);
            chk("store data", {16'h0, hi ? sv[31:16] : sv[15:0]}, rd);
            rdr(ADDR_MADDR);
            chk("store addr", {15'h0, 1'b1, dp, dma}, rd);
            rdr(ADDR_ACC);
            chk("acc kept", a, rd);
        end
        done("store_acc");
        for (int i = 0; i < 16; i++) begin
            aux_pointer = 3'($urandom);
            x = (i == 0) ? aux_pointer : 3'($urandom);
            aru = (i % 4 == 0) ? 3'h1 : (i % 4 == 1) ? 3'h2 : (i % 4 == 2) ? 3'h5 : 3'h6;
            hi = i[2];
            nar = 3'($urandom);
            for (int j = 0; j < 8; j++) begin
                ar[j] = 16'($urandom);
                wr(ADDR_AR0 + 8'(4 * j), {16'h0, ar[j]});
            end
            wr(ADDR_ARP, {29'h0, aux_pointer});
            wr(ADDR_STAT, 32'h1);
            run({OPC_SAR, x, 1'b1, aru, hi, nar});
            rdr(ADDR_MDATA);
            chk("sar data", {16'h0, ar[x]}, rd);
            rdr(ADDR_MADDR);
            chk("sar addr", {15'h0, 1'b1, ar[aux_pointer]}, rd & 32'h0001_FFFF);
            rdr(ADDR_AR0 + 8'(4 * aux_pointer));
            sv = {16'h0, (aru == 3'h1) ? ar[aux_pointer] - 16'h1 : (aru == 3'h2) ? ar[aux_pointer] + 16'h1
                        : (aru == 3'h5) ? ar[aux_pointer] - ar[0] : ar[aux_pointer] + ar[0]};
            chk("ar step", sv, rd);
            rdr(ADDR_ARP);
            chk("arp next", {29'h0, hi ? nar : aux_pointer}, rd);
            rdr(ADDR_STAT);
            chk("sar status", 32'h1, rd & 32'h1);
        end
        done("store_aux");
        for (int i = 0; i < 16; i++) begin
            aux_pointer = 3'($urandom);
            ar[0] = (i == 0) ? 16'h0 : 16'($urandom);
            k = (i == 0) ? 8'hFF : 8'($urandom);
            wr(ADDR_AR0 + 8'(4 * aux_pointer), {16'h0, ar[0]});
            wr(ADDR_ARP, {29'h0, aux_pointer});
            wr(ADDR_STAT, 32'h1);
            run({OPC_AUX_SUB_IMM_OP, k});
            rdr(ADDR_AR0 + 8'(4 * aux_pointer));
            chk("sub result", {16'h0, ar[0] - {8'h0, k}}, rd);
            rdr(ADDR_STAT);
            chk("sub status", 32'h1, rd & 32'h1);
        end
        done("aux_sub");
        wr(ADDR_MEMCFG, 32'h0);
        run({OPC_AUX_SUB_IMM_OP, 8'h0});
        base = t;
        for (int i = 0; i < 12; i++) begin
            cfg = (i == 0) ? 5'b01011 : (i == 1) ? 5'b10100 : 5'($urandom);
            d = 1 + $urandom % 6;
            p = 1 + $urandom % 6;
            k = 8'($urandom % 4);
            wr(ADDR_MEMCFG, {27'h0, cfg});
            wr(ADDR_WAIT, {16'h0, 8'(p), 8'(d)});
            run({OPC_AUX_SUB_IMM_OP, 8'h1});
            tchk(expc(0, cfg, 1, d, p));
            run({OPC_STORE_ACC_HIGH_OP, 3'h0, 1'b0, 7'h5});
            tchk(expc(2, cfg, 1, d, p));
            run({OPC_RPT_IMM, k});
            tchk(expc(0, cfg, 1, d, p));
            rdr(ADDR_REPEAT_COUNTER);
            chk("repeat_counter imm", {24'h0, k}, rd);
            run({OPC_STORE_ACC_LOW_OP, 3'h1, 1'b0, 7'h9});
            tchk(expc(3, cfg, k + 1, d, p));
            rdr(ADDR_REPEAT_COUNTER);
            chk("repeat_counter end", 32'h0, rd);
            wr(ADDR_OPND, {24'h0, k});
            run({OPC_RPT_MEM, 1'b0, 7'h3});
            tchk(expc(1, cfg, 1, d, p));
            rdr(ADDR_REPEAT_COUNTER);
            chk("repeat_counter mem", {24'h0, k}, rd);
            a = $urandom;
            c = 1'($urandom);
            wr(ADDR_ACC, a);
            wr(ADDR_STAT, {31'h0, c});
            run(OPC_ROR);
            tchk(expc(0, cfg, k + 1, d, p));
            for (int j = 0; j <= k; j++) begin
                {c, a} = {a[0], c, a[31:1]};
            end
            rdr(ADDR_ACC);
            chk("ror repeat", a, rd);
        end
        done("timing");
        close_out();
    end
endmodule : testbench
